// *** src/spd_dev.sv ***
// Device end: period measurement, division, filtering and shared result memory.
module spd_dev #(
    parameter logic [3:0] CH_PROX = 4'h0,
    parameter int MAG_TMO_US = spd_pkg::MAG_TMO_US,
    parameter int PROX_TMO_US = spd_pkg::PROX_TMO_US
) (
    // Processor link.
    spd_if.dev lnk,
    // Sensor side.
    input wire logic [3:0] pulse_in,
    output logic fault_led
);
    localparam int NCH = spd_pkg::NCH;
    localparam int PW = spd_pkg::PER_W;
    localparam int YW = spd_pkg::Y_W;

    typedef struct packed {
        spd_pkg::spd_dev_e st;
        logic [1:0] ch;
        logic [5:0] bit_n;
        logic [7:0] us_div;
        logic [6:0] smp;
        logic [NCH-1:0] pin_prev;
        logic [NCH-1:0][2:0] pre_cnt;
        logic [NCH-1:0][PW-1:0] cnt;
        logic [NCH-1:0][PW-1:0] per;
        logic [NCH-1:0] per_ok;
        logic [NCH-1:0] armed;
        logic [NCH-1:0][spd_pkg::GRP_W-1:0] grp;
        logic [NCH-1:0][spd_pkg::PRE_W-1:0] pre;
        logic [NCH-1:0][spd_pkg::FK_W-1:0] fk;
        logic [NCH-1:0][spd_pkg::FK_W-1:0] dk;
        logic [NCH-1:0][spd_pkg::NUM_W-1:0] num;
        logic [31:0] quo;
        logic [PW:0] rem;
        logic [PW-1:0] den;
        logic [NCH-1:0][YW-1:0] y1;
        logic [NCH-1:0][YW-1:0] y2;
        logic [NCH-1:0][YW-1:0] dd;
        logic [NCH-1:0][15:0] spd;
        logic [NCH-1:0][15:0] der;
        logic self_ok;
        logic init_q;
        logic led;
        logic [NCH-1:0][31:0] mem;
        logic [31:0] rd_q;
    } spd_dev_s;

    spd_dev_s r_q;
    spd_dev_s r_d;

    ////////////////////////////////////////////////////////////////////////////////

    function automatic logic [PW+32:0] div_step(logic [PW:0] rem, logic [31:0] quo,
                                                logic [PW-1:0] den);
        logic [PW:0] t;
        t = {rem[PW-1:0], quo[31]};
        quo = {quo[30:0], 1'b0};
        if (t >= {1'b0, den}) begin
            t = t - {1'b0, den};
            quo[0] = 1'b1;
        end
        return {t, quo};
    endfunction

    localparam int FK_W_T = spd_pkg::FK_W;

    function automatic logic [FK_W_T-1:0] clamp_k(logic [FK_W_T-1:0] k);
        if (k < spd_pkg::FK_MIN) begin
            return spd_pkg::FK_MIN;
        end
        if (k > spd_pkg::FK_MAX) begin
            return spd_pkg::FK_MAX;
        end
        return k;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        logic us_tick;
        logic smp_tick;
        logic [PW-1:0] tmo;
        logic [2:0] lim;
        logic [PW+32:0] step;
        logic [15:0] s;
        logic signed [YW:0] e;
        logic [YW-1:0] d;
        logic [1:0] c;
        r_d = r_q;
        us_tick = 1'b0;
        smp_tick = 1'b0;
        tmo = '0;
        lim = '0;
        step = '0;
        s = '0;
        e = '0;
        d = '0;
        c = r_q.ch;
        // The read word only moves on a read, so a key cannot change it under the processor.
        if (lnk.rd_en) begin
            r_d.rd_q = r_q.mem[lnk.rd_ch];
        end
        r_d.us_div = r_q.us_div + 8'h01;
        if (r_q.us_div == 8'(spd_pkg::US_CYC - 1)) begin
            r_d.us_div = 8'h00;
            us_tick = 1'b1;
            r_d.smp = r_q.smp + 7'h01;
            if (r_q.smp == 7'(spd_pkg::SAMPLE_US - 1)) begin
                r_d.smp = 7'h00;
                smp_tick = 1'b1;
            end
        end
        r_d.pin_prev = pulse_in;
        for (int i = 0; i < NCH; i++) begin
            tmo = CH_PROX[i] ? PW'(PROX_TMO_US) : PW'(MAG_TMO_US);
            lim = 3'((4'h1 << r_q.pre[i]) - 4'h1);
            if (us_tick && r_q.cnt[i] < tmo) begin
                r_d.cnt[i] = r_q.cnt[i] + PW'(1);
            end
            if (r_q.cnt[i] >= tmo) begin
                r_d.per_ok[i] = 1'b0;
                r_d.armed[i] = 1'b0;
            end
            if (pulse_in[i] && !r_q.pin_prev[i]) begin
                r_d.pre_cnt[i] = r_q.pre_cnt[i] + 3'h1;
                if (r_q.pre_cnt[i] >= lim) begin
                    r_d.pre_cnt[i] = 3'h0;
                    r_d.per[i] = r_q.cnt[i];
                    r_d.per_ok[i] = r_q.armed[i] && r_q.cnt[i] < tmo && r_q.cnt[i] != '0;
                    r_d.armed[i] = 1'b1;
                    r_d.cnt[i] = '0;
                end
            end
            if (lnk.key_stb && lnk.key[r_q.grp[i]]) begin
                r_d.mem[i] = {r_q.spd[i], r_q.der[i]};
            end
        end
        if (lnk.cfg_we) begin
            r_d.grp[lnk.cfg_ch] = lnk.cfg_grp;
            r_d.pre[lnk.cfg_ch] = lnk.cfg_pre;
            r_d.fk[lnk.cfg_ch] = lnk.cfg_fk;
            r_d.dk[lnk.cfg_ch] = lnk.cfg_dk;
            r_d.num[lnk.cfg_ch] = lnk.cfg_num;
            r_d.pre_cnt[lnk.cfg_ch] = 3'h0;
        end
        if (lnk.init_done) begin
            r_d.init_q = 1'b1;
        end
        // A held request from the processor always wins over the local release.
        r_d.led = lnk.led_on_req || !(r_q.self_ok && r_q.init_q);
        unique case (r_q.st)
            spd_pkg::ST_TEST: begin
                step = div_step(r_q.rem, r_q.quo, r_q.den);
                r_d.rem = step[PW+32:32];
                r_d.quo = step[31:0];
                r_d.bit_n = r_q.bit_n + 6'h01;
                if (r_q.bit_n == spd_pkg::DIV_LAST) begin
                    r_d.self_ok = (step[31:0] == spd_pkg::TEST_QUO);
                    r_d.st = spd_pkg::ST_IDLE;
                end
            end
            spd_pkg::ST_IDLE: begin
                if (smp_tick) begin
                    r_d.ch = 2'h0;
                    r_d.bit_n = 6'h00;
                    r_d.rem = '0;
                    r_d.quo = r_q.num[0];
                    r_d.den = r_q.per[0];
                    r_d.st = spd_pkg::ST_DIV;
                end
            end
            spd_pkg::ST_DIV: begin
                step = div_step(r_q.rem, r_q.quo, r_q.den);
                r_d.rem = step[PW+32:32];
                r_d.quo = step[31:0];
                r_d.bit_n = r_q.bit_n + 6'h01;
                if (r_q.bit_n == spd_pkg::DIV_LAST) begin
                    r_d.st = spd_pkg::ST_FILT;
                end
            end
            spd_pkg::ST_FILT: begin
                // The sample uses the last full period, not the open count.
                s = (r_q.quo[31:16] != 16'h0000) ? 16'hFFFF : r_q.quo[15:0];
                if (!r_q.per_ok[c] || r_q.den == '0) begin
                    s = 16'h0000;
                end
                r_d.spd[c] = s;
                e = $signed({1'b0, s, 16'h0000}) - $signed({1'b0, r_q.y1[c]});
                e = e >>> clamp_k(r_q.fk[c]);
                r_d.y1[c] = r_q.y1[c] + YW'(e);
                e = $signed({1'b0, r_q.y1[c]}) - $signed({1'b0, r_q.y2[c]});
                e = e >>> clamp_k(r_q.fk[c]);
                r_d.y2[c] = r_q.y2[c] + YW'(e);
                r_d.spd[c] = r_d.y2[c][YW-1:spd_pkg::FRAC];
                d = r_d.y2[c] - r_q.y2[c];
                e = $signed({d[YW-1], d}) - $signed({r_q.dd[c][YW-1], r_q.dd[c]});
                e = e >>> clamp_k(r_q.dk[c]);
                r_d.dd[c] = r_q.dd[c] + YW'(e);
                r_d.der[c] = r_q.dd[c][23:8];
                r_d.ch = c + 2'h1;
                r_d.bit_n = 6'h00;
                r_d.rem = '0;
                r_d.quo = r_q.num[c + 2'h1];
                r_d.den = r_q.per[c + 2'h1];
                r_d.st = (c == 2'h3) ? spd_pkg::ST_IDLE : spd_pkg::ST_DIV;
            end
        endcase
    end

    always_ff @(posedge lnk.ref_clk) begin
        if (lnk.srst) begin
            r_q <= '0;
            r_q.st <= spd_pkg::ST_TEST;
            r_q.quo <= spd_pkg::TEST_NUM;
            r_q.den <= spd_pkg::TEST_DEN;
            r_q.led <= 1'b1;
            // A pin already high at release must not look like a fresh edge.
            r_q.pin_prev <= pulse_in;
        end else begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    assign fault_led = r_q.led;
    assign lnk.self_ok = r_q.self_ok;
    assign lnk.rd_data = r_q.rd_q;
endmodule

// *** common/spd_pkg.sv ***
// Constants, timing counts and state types for the four-channel speed block.
package spd_pkg;
    localparam int NCH = 4;
    localparam int CLK_MHZ = 250;
    localparam int US_CYC = CLK_MHZ;
    localparam int SAMPLE_US = 100;
    localparam int MAG_MIN_HZ = 50;
    localparam int PROX_MIN_CHZ = 4;
    localparam int MAG_TMO_US = 1000000 / MAG_MIN_HZ;
    localparam int PROX_TMO_US = 100000000 / PROX_MIN_CHZ;
    localparam int RATE_BASE_MS = 5;
    localparam int RATE_BASE_CYC = RATE_BASE_MS * 1000 * CLK_MHZ;
    localparam int TEST_WAIT_CYC = 1000;
    localparam int SPD_W = 16;
    localparam int PER_W = 25;
    localparam int NUM_W = 32;
    localparam int Y_W = 32;
    localparam int FRAC = 16;
    localparam int GRP_W = 3;
    localparam int KEY_W = 8;
    localparam int PRE_W = 2;
    localparam int FK_W = 5;
    localparam logic [FK_W-1:0] FK_MIN = 5'h06;
    localparam logic [FK_W-1:0] FK_MAX = 5'h11;
    localparam logic [NUM_W-1:0] TEST_NUM = 32'h0001_0000;
    localparam logic [PER_W-1:0] TEST_DEN = 25'h000_0100;
    localparam logic [NUM_W-1:0] TEST_QUO = 32'h0000_0100;
    localparam logic [5:0] DIV_LAST = 6'h1F;
    typedef enum logic [3:0] {
        ST_TEST = 4'h1, ST_IDLE = 4'h2, ST_DIV = 4'h4, ST_FILT = 4'h8
    } spd_dev_e;
    typedef enum logic [3:0] {
        H_INIT = 4'h1, H_TEST = 4'h2, H_RUN = 4'h4, H_FAIL = 4'h8
    } spd_host_e;
endpackage

// *** common/spd_if.sv ***
// Link between the speed block and the system processor end.
interface spd_if (
    input wire logic ref_clk,
    input wire logic srst
);
    logic cfg_we;
    logic [1:0] cfg_ch;
    logic [spd_pkg::GRP_W-1:0] cfg_grp;
    logic [spd_pkg::PRE_W-1:0] cfg_pre;
    logic [spd_pkg::FK_W-1:0] cfg_fk;
    logic [spd_pkg::FK_W-1:0] cfg_dk;
    logic [spd_pkg::NUM_W-1:0] cfg_num;
    logic init_done;
    logic led_on_req;
    logic self_ok;
    logic key_stb;
    logic [spd_pkg::KEY_W-1:0] key;
    logic rd_en;
    logic [1:0] rd_ch;
    logic [31:0] rd_data;
    modport dev (
        input ref_clk, srst, cfg_we, cfg_ch, cfg_grp, cfg_pre, cfg_fk, cfg_dk,
        input cfg_num, init_done, led_on_req, key_stb, key, rd_en, rd_ch,
        output self_ok, rd_data
    );
    modport host (
        input ref_clk, srst, self_ok, rd_data,
        output cfg_we, cfg_ch, cfg_grp, cfg_pre, cfg_fk, cfg_dk, cfg_num,
        output init_done, led_on_req, key_stb, key, rd_en, rd_ch
    );
endinterface

// *** src/spd_host.sv ***
// Processor end: initialisation, indicator handling and rate-group keys.
module spd_host #(
    parameter int RATE_CYC = spd_pkg::RATE_BASE_CYC
) (
    // Link to the speed block.
    spd_if.host lnk,
    // Configuration from software.
    input wire logic usr_cfg_we,
    input wire logic [1:0] usr_cfg_ch,
    input wire logic [spd_pkg::GRP_W-1:0] usr_cfg_grp,
    input wire logic [spd_pkg::PRE_W-1:0] usr_cfg_pre,
    input wire logic [spd_pkg::FK_W-1:0] usr_cfg_fk,
    input wire logic [spd_pkg::FK_W-1:0] usr_cfg_dk,
    input wire logic [spd_pkg::NUM_W-1:0] usr_cfg_num,
    input wire logic usr_cfg_done,
    // Result reads.
    input wire logic usr_rd_en,
    input wire logic [1:0] usr_rd_ch,
    output logic [31:0] usr_rd_data,
    output logic usr_rd_valid,
    // Status.
    output logic usr_run,
    output logic usr_fail
);
    typedef struct packed {
        spd_pkg::spd_host_e st;
        logic cfg_we;
        logic [1:0] cfg_ch;
        logic [spd_pkg::GRP_W-1:0] grp;
        logic [spd_pkg::PRE_W-1:0] pre;
        logic [spd_pkg::FK_W-1:0] fk;
        logic [spd_pkg::FK_W-1:0] dk;
        logic [spd_pkg::NUM_W-1:0] num;
        logic init_done;
        logic led;
        logic [31:0] tmr;
        logic [spd_pkg::KEY_W-1:0] tick_n;
        logic key_stb;
        logic [spd_pkg::KEY_W-1:0] key;
        logic [1:0] rd_pipe;
        logic [1:0] rd_ch;
        logic [31:0] rd_data;
    } spd_host_s;

    spd_host_s h_q;
    spd_host_s h_d;

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        logic [spd_pkg::KEY_W-1:0] m;
        h_d = h_q;
        m = '0;
        h_d.cfg_we = 1'b0;
        h_d.key_stb = 1'b0;
        h_d.rd_pipe = {h_q.rd_pipe[0], usr_rd_en};
        h_d.rd_ch = usr_rd_ch;
        if (h_q.rd_pipe[1]) begin
            h_d.rd_data = lnk.rd_data;
        end
        unique case (h_q.st)
            spd_pkg::H_INIT: begin
                h_d.led = 1'b1;
                if (usr_cfg_we) begin
                    h_d.cfg_we = 1'b1;
                    h_d.cfg_ch = usr_cfg_ch;
                    h_d.grp = usr_cfg_grp;
                    h_d.pre = usr_cfg_pre;
                    h_d.fk = usr_cfg_fk;
                    h_d.dk = usr_cfg_dk;
                    h_d.num = usr_cfg_num;
                end else if (usr_cfg_done) begin
                    h_d.init_done = 1'b1;
                    h_d.tmr = '0;
                    h_d.st = spd_pkg::H_TEST;
                end
            end
            spd_pkg::H_TEST: begin
                h_d.tmr = h_q.tmr + 32'h1;
                if (lnk.self_ok) begin
                    h_d.led = 1'b0;
                    h_d.tmr = '0;
                    h_d.st = spd_pkg::H_RUN;
                end else if (h_q.tmr == 32'(spd_pkg::TEST_WAIT_CYC - 1)) begin
                    h_d.st = spd_pkg::H_FAIL;
                end
            end
            spd_pkg::H_RUN: begin
                h_d.tmr = h_q.tmr + 32'h1;
                if (h_q.tmr == 32'(RATE_CYC - 1)) begin
                    // Group g is due every 2^g base periods.
                    for (int g = 0; g < spd_pkg::KEY_W; g++) begin
                        m[g] = ((h_q.tick_n & 8'((9'h001 << g) - 9'h001)) == 8'h00);
                    end
                    h_d.tmr = '0;
                    h_d.tick_n = h_q.tick_n + 8'h01;
                    h_d.key = m;
                    h_d.key_stb = 1'b1;
                end
            end
            spd_pkg::H_FAIL: begin
                h_d.led = 1'b1;
            end
        endcase
    end

    always_ff @(posedge lnk.ref_clk) begin
        if (lnk.srst) begin
            h_q <= '0;
            h_q.st <= spd_pkg::H_INIT;
            h_q.led <= 1'b1;
        end else begin
            h_q <= h_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    assign lnk.cfg_we = h_q.cfg_we;
    assign lnk.cfg_ch = h_q.cfg_ch;
    assign lnk.cfg_grp = h_q.grp;
    assign lnk.cfg_pre = h_q.pre;
    assign lnk.cfg_fk = h_q.fk;
    assign lnk.cfg_dk = h_q.dk;
    assign lnk.cfg_num = h_q.num;
    assign lnk.init_done = h_q.init_done;
    assign lnk.led_on_req = h_q.led;
    assign lnk.key_stb = h_q.key_stb;
    assign lnk.key = h_q.key;
    assign lnk.rd_en = h_q.rd_pipe[0];
    assign lnk.rd_ch = h_q.rd_ch;
    assign usr_rd_data = h_q.rd_data;
    assign usr_rd_valid = h_q.rd_pipe[1];
    assign usr_run = (h_q.st == spd_pkg::H_RUN);
    assign usr_fail = (h_q.st == spd_pkg::H_FAIL);
endmodule

// *** verification/spd_checker.sv ***
// Concurrent checks on the link between the speed block and the processor end.
module spd_checker (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    // Configuration and control from the processor end.
    input wire logic cfg_we,
    input wire logic [1:0] cfg_ch,
    input wire logic [spd_pkg::GRP_W-1:0] cfg_grp,
    input wire logic [spd_pkg::PRE_W-1:0] cfg_pre,
    input wire logic [spd_pkg::FK_W-1:0] cfg_fk,
    input wire logic [spd_pkg::FK_W-1:0] cfg_dk,
    input wire logic [spd_pkg::NUM_W-1:0] cfg_num,
    input wire logic init_done,
    input wire logic led_on_req,
    input wire logic key_stb,
    input wire logic [spd_pkg::KEY_W-1:0] key,
    input wire logic rd_en,
    input wire logic [1:0] rd_ch,
    // Answers from the device end.
    input wire logic self_ok,
    input wire logic [31:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////////
    property p_led_first;
        $fell(srst) |-> led_on_req && !init_done;
    endproperty
    a_led_first: assert property (p_led_first)
        else $error("indicator request missing after reset");
    property p_led_init;
        !init_done |-> led_on_req;
    endproperty
    a_led_init: assert property (p_led_init)
        else $error("indicator released before initialisation");
    property p_led_off;
        $fell(led_on_req) |-> self_ok && init_done;
    endproperty
    a_led_off: assert property (p_led_off)
        else $error("indicator released without self-test and init");
    property p_selftest;
        $fell(srst) |-> !self_ok [*8] ##[1:40] self_ok;
    endproperty
    a_selftest: assert property (p_selftest)
        else $error("self-test result out of its window");
    property p_cfg_init;
        cfg_we |-> !init_done;
    endproperty
    a_cfg_init: assert property (p_cfg_init)
        else $error("channel setting sent after initialisation");
    property p_init_sticky;
        $rose(init_done) |=> init_done [*8];
    endproperty
    a_init_sticky: assert property (p_init_sticky)
        else $error("initialisation flag dropped");
    property p_key_grp0;
        key_stb |-> key[0] && init_done && !led_on_req;
    endproperty
    a_key_grp0: assert property (p_key_grp0)
        else $error("key without base group or outside run");
    property p_key_space;
        key_stb |=> !key_stb [*8] ##[1:600] key_stb;
    endproperty
    a_key_space: assert property (p_key_space)
        else $error("key spacing wrong");
    property p_rd_hold;
        !rd_en && !key_stb |=> $stable(rd_data);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read word changed without a read");
    ////////////////////////////////////////////////////////////////////////////////
    c_key: cover property (key_stb);
    c_led_off: cover property ($fell(led_on_req));
    c_read: cover property (rd_en);
    c_cfg: cover property (cfg_we);
endmodule

// *** verification/tb_four_channel_speed_measurement.sv ***
// Self-checking bench for the device and processor ends joined by their link.
module tb_four_channel_speed_measurement;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic usr_cfg_we, usr_cfg_done, usr_rd_en, usr_rd_valid, usr_run, usr_fail, fault_led;
    logic [1:0] usr_cfg_ch, usr_rd_ch;
    logic [spd_pkg::GRP_W-1:0] usr_cfg_grp;
    logic [spd_pkg::PRE_W-1:0] usr_cfg_pre;
    logic [spd_pkg::FK_W-1:0] usr_cfg_fk, usr_cfg_dk;
    logic [spd_pkg::NUM_W-1:0] usr_cfg_num;
    logic [31:0] usr_rd_data;
    logic [3:0] pulse_in;
    logic tgl = 1'b0;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [15:0] q_lo[$];
    logic [15:0] q_hi[$];
    logic q_dz[$];
    ////////////////////////////////////////////////////////////////////////////////
    spd_if lnk (.ref_clk(ref_clk), .srst(srst));
    // Short timeouts keep the run small; channel 3 is the proximity one.
    spd_dev #(.CH_PROX(4'h8), .MAG_TMO_US(200), .PROX_TMO_US(2000)) u_spd_dev (
        .lnk(lnk), .pulse_in(pulse_in), .fault_led(fault_led));
    spd_host #(.RATE_CYC(500)) u_spd_host (
        .lnk(lnk), .usr_cfg_we(usr_cfg_we), .usr_cfg_ch(usr_cfg_ch),
        .usr_cfg_grp(usr_cfg_grp), .usr_cfg_pre(usr_cfg_pre), .usr_cfg_fk(usr_cfg_fk),
        .usr_cfg_dk(usr_cfg_dk), .usr_cfg_num(usr_cfg_num), .usr_cfg_done(usr_cfg_done),
        .usr_rd_en(usr_rd_en), .usr_rd_ch(usr_rd_ch), .usr_rd_data(usr_rd_data),
        .usr_rd_valid(usr_rd_valid), .usr_run(usr_run), .usr_fail(usr_fail));
    spd_checker u_spd_checker (
        .ref_clk(ref_clk), .srst(srst), .cfg_we(lnk.cfg_we), .cfg_ch(lnk.cfg_ch),
        .cfg_grp(lnk.cfg_grp), .cfg_pre(lnk.cfg_pre), .cfg_fk(lnk.cfg_fk),
        .cfg_dk(lnk.cfg_dk), .cfg_num(lnk.cfg_num), .init_done(lnk.init_done),
        .led_on_req(lnk.led_on_req), .key_stb(lnk.key_stb), .key(lnk.key),
        .rd_en(lnk.rd_en), .rd_ch(lnk.rd_ch), .self_ok(lnk.self_ok), .rd_data(lnk.rd_data));
    ////////////////////////////////////////////////////////////////////////////////
    always #2 ref_clk = ~ref_clk;
    // A 4 us square wave on channels 0, 1 and 3; channel 2 stays silent.
    assign pulse_in = {tgl, 1'b0, tgl, tgl};
    always @(posedge ref_clk) begin
        #1;
        cyc++;
        if (cyc % 500 == 0) begin
            tgl = ~tgl;
        end
        if (cyc == 70000) begin
            n_mismatch++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("Checks made: %0d, mismatches: %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic fail(input string msg);
        n_mismatch++;
        $display("ERROR at %0t ns: %s", $time, msg);
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            fail(msg);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [15:0] lo,
                            input logic [15:0] hi, input logic dz);
        logic ok;
        ok = (got[31:16] >= lo) && (got[31:16] <= hi) && (!dz || got[15:0] == 16'h0000);
        n_tests++;
        if (ok !== 1'b1) begin
            fail("read word out of expected range");
        end
    endtask
    // The caller lowers the write strobe, so writes may run back to back.
    task automatic cfg(input logic [1:0] ch, input logic [spd_pkg::GRP_W-1:0] grp,
                       input logic [spd_pkg::PRE_W-1:0] pre);
        usr_cfg_we = 1'b1;
        usr_cfg_ch = ch;
        usr_cfg_grp = grp;
        usr_cfg_pre = pre;
        usr_cfg_fk = spd_pkg::FK_MIN;
        usr_cfg_dk = spd_pkg::FK_MIN + 5'($urandom_range(11, 0));
        usr_cfg_num = 32'h0003_C000;
        tick();
    endtask
    // Reads are spaced so that each answer is seen on its own.
    task automatic rd(input logic [1:0] ch, input logic [15:0] lo, input logic [15:0] hi,
                      input logic dz);
        q_lo.push_back(lo);
        q_hi.push_back(hi);
        q_dz.push_back(dz);
        usr_rd_ch = ch;
        usr_rd_en = 1'b1;
        tick();
        usr_rd_en = 1'b0;
        repeat (4) tick();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        #1;
        if (usr_rd_valid === 1'b1) begin
            // The word is captured at the edge that closes the valid stage.
            tick();
            if (q_lo.size() == 0) begin
                fail("read answer without a request");
            end else begin
                chk_word(usr_rd_data, q_lo.pop_front(), q_hi.pop_front(), q_dz.pop_front());
            end
        end
    end
    initial begin
        usr_cfg_we = 1'b0;
        usr_cfg_ch = 2'h0;
        usr_cfg_grp = 3'h0;
        usr_cfg_pre = 2'h0;
        usr_cfg_fk = 5'h00;
        usr_cfg_dk = 5'h00;
        usr_cfg_num = 32'h0000_0000;
        usr_cfg_done = 1'b0;
        usr_rd_en = 1'b0;
        usr_rd_ch = 2'h0;
        void'($urandom(13302));
        repeat (20) tick();
        chk_bit(fault_led, 1'b1, "indicator off in reset");
        chk_bit(usr_run, 1'b0, "run flag set in reset");
        srst = 1'b0;
        repeat (50) tick();
        chk_bit(fault_led, 1'b1, "indicator off before init");
        chk_bit(usr_run, 1'b0, "run flag set before init");
        cfg(2'h0, 3'h0, 2'h0);
        cfg(2'h1, 3'h0, 2'h1);
        cfg(2'h2, 3'h0, 2'h2);
        cfg(2'h3, 3'h7, 2'h3);
        usr_cfg_we = 1'b0;
        usr_cfg_done = 1'b1;
        tick();
        usr_cfg_done = 1'b0;
        repeat (40) tick();
        chk_bit(usr_run, 1'b1, "run flag missing");
        chk_bit(usr_fail, 1'b0, "fail flag set");
        chk_bit(fault_led, 1'b0, "indicator stuck on");
        // A write after initialisation must be ignored, so channel 0 keeps group 0.
        cfg(2'h0, 3'h7, 2'h3);
        usr_cfg_we = 1'b0;
        repeat (60000) tick();
        rd(2'h0, 16'h0001, 16'hF000, 1'b0);
        rd(2'h1, 16'h0001, 16'h7800, 1'b0);
        rd(2'h2, 16'h0000, 16'h0000, 1'b1);
        rd(2'h3, 16'h0000, 16'h0000, 1'b1);
        chk_bit(q_lo.size() == 0, 1'b1, "read answer missing");
        end_sim();
    end
endmodule
